// [verilog/buck_prot_top.sv]
/*
 * protection and fault-flag logic of a dual synchronous buck stage with an
 * AHB-Lite register slave (zero wait state, always OKAY).
 * assumes pin inputs are asynchronous and the thermal comparators give
 * level outputs for the trip point and the hysteresis lower edge.
 */
`timescale 1ns/100ps

// Functional notes
// [R1] each channel latches its fault flag high when its high-side current passes the limit.
// [R2] while a channel's limit is tripped its high-side pulse is cut short.
// [R3] a channel's fault flag clears after one whole switching cycle without over-current.
// [R4] above 170 C the device shuts down, stops switching and raises the fault flags.
// [R5] after shutdown flags clear and switching resumes only below the hysteresis lower edge.
// [R6] in shutdown the temperature output is pulled to the logic rail and all switches are off.
// [R7] each channel has its own digital fault flag output readable by the controller.
// [R8] in sync mode with pwm high the high side is on and the low side off.
// [R9] in sync mode with pwm low the low side is on, with a dead time between transitions.
// [R10] with sync rectification off the low side stays off and pwm drives only the high side.
// [R11] a switching cycle runs from one pwm rising edge to the next.
module buck_prot_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        chan_a_pwm,
    input  wire logic        chan_b_pwm,
    input  wire logic        chan_a_sync_rectifier_enable,
    input  wire logic        chan_b_sync_rectifier_enable,
    input  wire logic        chan_a_over_current,
    input  wire logic        chan_b_over_current,
    input  wire logic        temp_above_trip,
    input  wire logic        temp_below_hyst,
    output logic             chan_a_hs_gate,
    output logic             chan_a_ls_gate,
    output logic             chan_b_hs_gate,
    output logic             chan_b_ls_gate,
    output logic             chan_a_fault_flag,
    output logic             chan_b_fault_flag,
    output logic             die_temp_sense_out
);

    localparam int NPIN = 8;
    localparam int DW   = buck_prot_pkg::DEAD_W;

    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    logic            shutdown;
    logic [DW-1:0]   dead_cycles;
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic            fault_a;
    logic            fault_b;
    logic            hs_a;
    logic            ls_a;
    logic            hs_b;
    logic            ls_b;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire [NPIN-1:0] pins = {temp_below_hyst, temp_above_trip,
                            chan_b_over_current, chan_a_over_current,
                            chan_b_sync_rectifier_enable, chan_a_sync_rectifier_enable,
                            chan_b_pwm, chan_a_pwm};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= pins;
            pin_sync <= pin_meta;
        end
    end

    wire over_temp = pin_sync[6];
    wire cooled    = pin_sync[7];

    // ------------------------------------------------------------
    // thermal shutdown
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            shutdown <= 1'b0;
        // [R4] enter on over-temperature
        else if (over_temp)
            shutdown <= 1'b1;
        // [R5] leave below hysteresis
        else if (cooled)
            shutdown <= 1'b0;
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    buck_channel #(.DEAD_W(DW)) chan_a (
        .hclk                  (hclk),
        .hresetn               (hresetn),
        .pwm                   (pin_sync[0]),
        .sync_rectifier_enable (pin_sync[2]),
        .over_current          (pin_sync[4]),
        .shutdown              (shutdown),
        .dead_cycles           (dead_cycles),
        .hs_gate               (hs_a),
        .ls_gate               (ls_a),
        .fault_flag            (fault_a)
    );

    buck_channel #(.DEAD_W(DW)) chan_b (
        .hclk                  (hclk),
        .hresetn               (hresetn),
        .pwm                   (pin_sync[1]),
        .sync_rectifier_enable (pin_sync[3]),
        .over_current          (pin_sync[5]),
        .shutdown              (shutdown),
        .dead_cycles           (dead_cycles),
        .hs_gate               (hs_b),
        .ls_gate               (ls_b),
        .fault_flag            (fault_b)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // [R6] switches forced off in shutdown
    assign chan_a_hs_gate     = hs_a & ~shutdown;
    assign chan_a_ls_gate     = ls_a & ~shutdown;
    assign chan_b_hs_gate     = hs_b & ~shutdown;
    assign chan_b_ls_gate     = ls_b & ~shutdown;
    // [R7] one flag per channel
    assign chan_a_fault_flag  = fault_a | shutdown;
    assign chan_b_fault_flag  = fault_b | shutdown;
    // [R6] sense output at rail
    assign die_temp_sense_out = shutdown;

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    wire addr_phase = hsel & hready & htrans[1];
    wire rd_ctrl    = haddr == buck_prot_pkg::CTRL_OFFSET;
    wire rd_status  = haddr == buck_prot_pkg::STATUS_OFFSET;

    wire [31:0] status_word = {25'h0000000, ls_b & ~shutdown, hs_b & ~shutdown,
                               ls_a & ~shutdown, hs_a & ~shutdown, shutdown,
                               fault_b | shutdown, fault_a | shutdown};
    wire [31:0] ctrl_word   = {{(32 - DW){1'b0}}, dead_cycles};
    wire [31:0] next_hrdata = rd_ctrl   ? ctrl_word :
                              rd_status ? status_word : 32'h00000000;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata  <= 32'h00000000;
        end
        else
        begin
            wr_pend <= addr_phase & hwrite;
            if (addr_phase)
                wr_addr <= haddr;
            if (addr_phase && !hwrite)
                hrdata <= next_hrdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dead_cycles <= buck_prot_pkg::CTRL_DEAD_RESET;
        else if (wr_pend && wr_addr == buck_prot_pkg::CTRL_OFFSET)
            dead_cycles <= hwdata[buck_prot_pkg::CTRL_DEAD_LSB +: DW];
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_enter_shutdown;
        @(posedge hclk) disable iff (!hresetn)
        over_temp |=> shutdown && chan_a_fault_flag && chan_b_fault_flag;
    endproperty
    a_enter_shutdown: assert property (p_enter_shutdown) // [R4]
        else $error("shutdown or flags missing after over-temperature");

    property p_hold_shutdown;
        @(posedge hclk) disable iff (!hresetn)
        (shutdown && !cooled) |=> shutdown;
    endproperty
    a_hold_shutdown: assert property (p_hold_shutdown) // [R5]
        else $error("shutdown left before cooling");

    property p_leave_shutdown;
        @(posedge hclk) disable iff (!hresetn)
        (shutdown && cooled && !over_temp) |=> !shutdown;
    endproperty
    a_leave_shutdown: assert property (p_leave_shutdown) // [R5]
        else $error("shutdown not left after cooling");

    property p_shutdown_outputs;
        @(posedge hclk) disable iff (!hresetn)
        shutdown |-> die_temp_sense_out && !chan_a_hs_gate && !chan_a_ls_gate
                     && !chan_b_hs_gate && !chan_b_ls_gate;
    endproperty
    a_shutdown_outputs: assert property (p_shutdown_outputs) // [R6]
        else $error("switching or sense output wrong in shutdown");

    property p_flag_pin_to_out;
        @(posedge hclk) disable iff (!hresetn)
        $rose(pin_sync[4]) |=> chan_a_fault_flag;
    endproperty
    a_flag_pin_to_out: assert property (p_flag_pin_to_out) // [R7] [R1]
        else $error("channel a flag output missing");

endmodule

// [verilog/buck_prot_pkg.sv]
/*
 * constants for the dual buck protection logic: register map, field
 * positions, reset values and timing counts.
 * assumes a 125 MHz hclk and 32-bit word-aligned register access.
 */
package buck_prot_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 8;
    localparam int DEAD_TIME_NS      = 20;
    localparam int DEAD_TIME_CYCLES  = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_W            = 4;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    localparam int CTRL_DEAD_LSB   = 0;
    localparam logic [DEAD_W-1:0] CTRL_DEAD_RESET = DEAD_W'(DEAD_TIME_CYCLES);

    localparam int STAT_FAULT_A    = 0;
    localparam int STAT_FAULT_B    = 1;
    localparam int STAT_SHUTDOWN   = 2;
    localparam int STAT_HS_A       = 3;
    localparam int STAT_LS_A       = 4;
    localparam int STAT_HS_B       = 5;
    localparam int STAT_LS_B       = 6;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// [verilog/buck_channel.sv]
/*
 * one buck channel: gate sequencing with dead time, high-side pulse
 * truncation and over-current fault flag.
 * assumes pwm, sre and over-current inputs are already synchronised to hclk.
 */
`timescale 1ns/100ps

module buck_channel #(
    parameter int DEAD_W = 4
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              pwm,
    input  wire logic              sync_rectifier_enable,
    input  wire logic              over_current,
    input  wire logic              shutdown,
    input  wire logic [DEAD_W-1:0] dead_cycles,
    output logic                   hs_gate,
    output logic                   ls_gate,
    output logic                   fault_flag
);

    logic              pwm_prev;
    logic              truncated;
    logic              oc_seen;
    logic [DEAD_W-1:0] dead_cnt;

    wire pwm_rise  = pwm & ~pwm_prev;
    wire both_off  = ~hs_gate & ~ls_gate;
    wire dead_done = both_off && (dead_cnt >= dead_cycles);
    wire hs_req    = pwm & ~truncated & ~over_current & ~shutdown;
    wire ls_req    = sync_rectifier_enable & ~pwm & ~shutdown;

    // ------------------------------------------------------------
    // cycle tracking and fault flag
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwm_prev   <= 1'b0;
            truncated  <= 1'b0;
            oc_seen    <= 1'b0;
            fault_flag <= 1'b0;
        end
        else
        begin
            pwm_prev <= pwm;
            // [R2] truncate until next cycle
            truncated <= over_current | (truncated & ~pwm_rise);
            // [R11] cycle ends at pwm rise
            oc_seen <= over_current | (oc_seen & ~pwm_rise);
            // [R1] latch on over-current
            // [R3] clear after clean cycle
            fault_flag <= over_current | (fault_flag & ~(pwm_rise & ~oc_seen));
        end
    end

    // ------------------------------------------------------------
    // gate drive with dead time
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hs_gate  <= 1'b0;
            ls_gate  <= 1'b0;
            dead_cnt <= '0;
        end
        else
        begin
            // [R8] pwm high drives high side
            hs_gate <= hs_req & (hs_gate | dead_done);
            // [R9] [R10] low side only in sync mode
            ls_gate <= ls_req & (ls_gate | dead_done);
            if (!both_off)
                dead_cnt <= '0;
            else if (dead_cnt != {DEAD_W{1'b1}})
                dead_cnt <= dead_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_oc_sets_flag;
        @(posedge hclk) disable iff (!hresetn)
        over_current |=> fault_flag;
    endproperty
    a_oc_sets_flag: assert property (p_oc_sets_flag) // [R1]
        else $error("fault flag not set after over-current");

    property p_truncate;
        @(posedge hclk) disable iff (!hresetn)
        over_current |=> !hs_gate;
    endproperty
    a_truncate: assert property (p_truncate) // [R2]
        else $error("high side on while current limit tripped");

    property p_clear_clean;
        @(posedge hclk) disable iff (!hresetn)
        (pwm_rise && !oc_seen && !over_current) |=> !fault_flag;
    endproperty
    a_clear_clean: assert property (p_clear_clean) // [R3] [R11]
        else $error("fault flag not cleared after clean cycle");

    property p_no_overlap;
        @(posedge hclk) disable iff (!hresetn)
        !(hs_gate && ls_gate) and ($fell(hs_gate) |-> !ls_gate);
    endproperty
    a_no_overlap: assert property (p_no_overlap) // [R8] [R9]
        else $error("high and low side overlap");

    property p_ls_off_async;
        @(posedge hclk) disable iff (!hresetn)
        !sync_rectifier_enable |=> !ls_gate;
    endproperty
    a_ls_off_async: assert property (p_ls_off_async) // [R10]
        else $error("low side on with sync rectification off");

    property p_hs_follows_pwm;
        @(posedge hclk) disable iff (!hresetn)
        (dead_done && hs_req) |=> hs_gate;
    endproperty
    a_hs_follows_pwm: assert property (p_hs_follows_pwm) // [R8]
        else $error("high side not turned on");

endmodule

// [testbench/pwm_ctrl_model.sv]
/*
 * behavioural pwm controller driving one channel's pwm pin.
 * assumes hclk and hresetn from the bench, which sets period and high time.
 */
`timescale 1ns/100ps

module pwm_ctrl_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       enable,
    input  wire logic [7:0] period,
    input  wire logic [7:0] high,
    output logic            pwm
);
    logic [7:0] count;

    // pin held low while stopped, so no stale level
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= 8'h00;
            pwm   <= 1'b0;
        end
        else if (!enable)
        begin
            count <= 8'h00;
            pwm   <= 1'b0;
        end
        else
        begin
            count <= (count + 8'h01 >= period) ? 8'h00 : count + 8'h01;
            pwm   <= (count < high);
        end
    end
endmodule

// [testbench/buck_prot_top_tb.sv]
/*
 * self-checking bench for buck_prot_top: bus, gates, faults, thermal.
 * assumes the design package and pwm_ctrl_model are compiled first.
 */
`timescale 1ns/100ps

module buck_prot_top_tb;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr, per_a, hi_a, per_b, hi_b;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic        pwm_a, pwm_b, sync_en_a, sync_en_b, oc_a, oc_b, trip, cool, run;
    logic        hs_a, ls_a, hs_b, ls_b, fault_a, fault_b, sense;
    logic        prev_on, hs_b_seen, ls_b_seen;
    int          fail_count, comparisons, seed, dead, off_run;

    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    buck_prot_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .chan_a_pwm(pwm_a), .chan_b_pwm(pwm_b), .chan_a_sync_rectifier_enable(sync_en_a),
        .chan_b_sync_rectifier_enable(sync_en_b), .chan_a_over_current(oc_a),
        .chan_b_over_current(oc_b), .temp_above_trip(trip), .temp_below_hyst(cool),
        .chan_a_hs_gate(hs_a), .chan_a_ls_gate(ls_a), .chan_b_hs_gate(hs_b),
        .chan_b_ls_gate(ls_b), .chan_a_fault_flag(fault_a),
        .chan_b_fault_flag(fault_b), .die_temp_sense_out(sense));

    pwm_ctrl_model u_ctrl_a (.hclk(hclk), .hresetn(hresetn), .enable(run),
        .period(per_a), .high(hi_a), .pwm(pwm_a));
    pwm_ctrl_model u_ctrl_b (.hclk(hclk), .hresetn(hresetn), .enable(run),
        .period(per_b), .high(hi_b), .pwm(pwm_b));

    // ------------------------------------------------------------
    // compare, bus and wait tasks
    // ------------------------------------------------------------
    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: bit got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: word got %h exp %h", $time, got, exp);
        end
    endtask

    // expected status word from channel flags and shutdown
    function automatic logic [31:0] status_exp(input logic fa, input logic fb, input logic sd);
        return {29'h0, sd, fb | sd, fa | sd};
    endfunction

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'h2;
        htrans <= buck_prot_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic edges(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic wait_rise;
        logic p;
        for (int k = 0; k < 200; k++)
        begin
            p = pwm_a;
            edges(1);
            if (!p && pwm_a)
                break;
        end
    endtask

    task automatic print_verdict;
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // gate monitor: channel a dead time and no cross conduction on either channel
    // ------------------------------------------------------------
    always @(negedge hclk)
    begin
        if (hresetn)
        begin
            if ((hs_a | ls_a) && !prev_on)
                chk1(off_run >= dead, 1'b1);
            chk1(hs_a & ls_a, 1'b0);
            chk1(hs_b & ls_b, 1'b0);
            off_run = (hs_a | ls_a) ? 0 : off_run + 1;
            prev_on = hs_a | ls_a;
            hs_b_seen |= hs_b;
            ls_b_seen |= ls_b;
        end
    end

    initial
    begin
        edges(20000);
        fail_count++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'hE231;
        fail_count = 0;
        comparisons = 0;
        off_run = 0;
        prev_on = 1'b0;
        dead = buck_prot_pkg::CTRL_DEAD_RESET;
        {hresetn, hsel, hwrite, sync_en_a, sync_en_b, oc_a, oc_b, trip, run} = 9'h000;
        {haddr, htrans, hsize, hwdata, cool} = {8'h00, 2'h0, 3'h2, 32'h0, 1'b1};
        {per_a, hi_a, per_b, hi_b} = {8'h18, 8'h0C, 8'h20, 8'h08};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        edges(3);
        chk1(fault_a | fault_b | sense, 1'b0);
        ahb(1'b0, buck_prot_pkg::CTRL_OFFSET, 32'h0);
        chk32(rd, 32'(dead));
        chk1(hresp, 1'b0);
        ahb(1'b1, buck_prot_pkg::STATUS_OFFSET, 32'hFFFFFFFF);
        ahb(1'b0, buck_prot_pkg::STATUS_OFFSET, 32'h0);
        chk32(rd, status_exp(1'b0, 1'b0, 1'b0));
        ahb(1'b1, 8'h08, 32'hFFFFFFFF);
        ahb(1'b0, 8'h08, 32'h0);
        chk32(rd, 32'h0);
        ahb(1'b0, buck_prot_pkg::CTRL_OFFSET, 32'h0);
        chk32(rd, 32'(dead));
        sync_en_a <= 1'b1;
        for (int n = 0; n < 4; n++)
        begin
            run <= 1'b0;
            edges(12);
            dead = 1 + ({$random(seed)} % 15);
            ahb(1'b1, buck_prot_pkg::CTRL_OFFSET, 32'(dead));
            ahb(1'b0, buck_prot_pkg::CTRL_OFFSET, 32'h0);
            chk32(rd, 32'(dead));
            per_a <= 8'(20 + {$random(seed)} % 40);
            hi_a <= 8'(4 + {$random(seed)} % 12);
            hs_b_seen = 1'b0;
            ls_b_seen = 1'b0;
            run <= 1'b1;
            edges(150);
            chk1(ls_b_seen, 1'b0);
            chk1(hs_b_seen, 1'b1);
        end
        per_a <= 8'(2 * dead + 30);
        hi_a <= 8'(dead + 12);
        edges(80);
        wait_rise();
        oc_a <= 1'b1;
        edges(4);
        chk1(fault_a, 1'b1);
        chk1(hs_a, 1'b0);
        chk1(fault_b, 1'b0);
        ahb(1'b0, buck_prot_pkg::STATUS_OFFSET, 32'h0);
        chk32(rd & 32'h7, status_exp(1'b1, 1'b0, 1'b0));
        oc_a <= 1'b0;
        edges(4);
        chk1(hs_a, 1'b0);
        wait_rise();
        edges(dead + 6);
        chk1(fault_a, 1'b1);
        chk1(hs_a, 1'b1);
        chk1(ls_a, 1'b0);
        ahb(1'b0, buck_prot_pkg::STATUS_OFFSET, 32'h0);
        chk32(rd & 32'h1F, status_exp(1'b1, 1'b0, 1'b0) | 32'h8);
        wait_rise();
        edges(4);
        chk1(fault_a, 1'b0);
        trip <= 1'b1;
        cool <= 1'b0;
        edges(4);
        chk1(fault_a & fault_b & sense, 1'b1);
        chk1(hs_a | ls_a | hs_b | ls_b, 1'b0);
        ahb(1'b0, buck_prot_pkg::STATUS_OFFSET, 32'h0);
        chk32(rd, status_exp(1'b0, 1'b0, 1'b1));
        trip <= 1'b0;
        edges(8);
        chk1(sense & fault_b, 1'b1);
        cool <= 1'b1;
        edges(4);
        chk1(sense | fault_a | fault_b, 1'b0);
        wait_rise();
        edges(dead + 6);
        chk1(hs_a, 1'b1);
        edges(dead + 12);
        chk1(ls_a, 1'b1);
        chk1(hs_a, 1'b0);
        print_verdict();
    end
endmodule
